// ### common/scp_pkg.sv
// constants and types for the serial config and pump control register bank
package scp_pkg;
  // ---------------------------------------------------------------
  // serial instruction format
  // ---------------------------------------------------------------
  localparam int INSTR_BITS = 16;
  localparam int DATA_BITS = 8;
  localparam int ADDR_W = 13;
  localparam int RW_BIT = 15;
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [2:0] DATA_LAST = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 13'h0001;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_SERIAL_CFG = 13'h0000;
  localparam logic [ADDR_W-1:0] ADDR_READBACK_SEL = 13'h0004;
  localparam logic [ADDR_W-1:0] ADDR_BUF_TRANSFER = 13'h0005;
  localparam logic [ADDR_W-1:0] ADDR_PUMP_CURRENT = 13'h000A;
  localparam logic [ADDR_W-1:0] ADDR_PUMP_CTRL = 13'h000B;
  localparam logic [ADDR_W-1:0] ADDR_ANTIBACKLASH = 13'h000D;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CFG_LSB_FIRST = 6;
  localparam int CFG_SOFT_RESET = 5;
  localparam int READBACK_BIT = 0;
  localparam int UPDATE_BIT = 0;
  localparam int CTL_CUR_EN = 7;
  localparam int CTL_ABL_EN = 6;
  localparam int CTL_MODE_HI = 5;
  localparam int CTL_MODE_LO = 4;
  localparam int CTL_DISABLE = 3;
  localparam int CTL_FB_EDGE = 2;
  localparam int CTL_REF_EDGE = 1;
  localparam int CTL_VCO_MID = 0;
  localparam int ABL_HI = 7;
  localparam int ABL_LO = 6;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PUMP_CURRENT = 8'h80;
  localparam logic [7:0] RST_PUMP_CTRL = 8'h30;
  localparam logic [1:0] RST_ANTIBACKLASH = 2'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PUMP_TRISTATE = 2'b00,
    PUMP_UP = 2'b01,
    PUMP_DOWN = 2'b10,
    PUMP_NORMAL = 2'b11
  } scp_pump_mode_type;

  typedef enum logic [1:0] {
    ABL_MIN = 2'b00,
    ABL_LOW = 2'b01,
    ABL_HIGH = 2'b10,
    ABL_MAX = 2'b11
  } scp_abl_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA = 2'b10
  } scp_state_type;
endpackage

// ### common/scp_pump_if.sv
// active pump control values passed from the register bank to the decoder
`timescale 1ns/1ps
interface scp_pump_if;
  logic [7:0] cur;
  logic [7:0] ctl;
  logic [1:0] abl;
  modport bank (output cur, output ctl, output abl);
  modport dec (input cur, input ctl, input abl);
endinterface

// ### hw/scp_edge.sv
// serial clock edge and chip select detector
`timescale 1ns/1ps
module scp_edge (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  output logic sel,
  output logic rise,
  output logic fall
);
  logic sclk_d_r;

  // previous serial clock level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk;
    end
  end

  // edges count only while the port is selected
  assign sel = ~cs_n;
  assign rise = sel & sclk & ~sclk_d_r;
  assign fall = sel & ~sclk & sclk_d_r;
endmodule

// ### hw/scp_pump_decode.sv
// turns active pump register values into registered control outputs
`timescale 1ns/1ps
module scp_pump_decode (
  input wire logic clk,
  input wire logic reset,
  scp_pump_if.dec act,
  output logic [7:0] pump_current_code,
  output logic pump_current_spi_en,
  output scp_pkg::scp_pump_mode_type pump_mode,
  output logic abl_spi_en,
  output scp_pkg::scp_abl_type abl_period,
  output logic fb_edge_falling,
  output logic ref_edge_falling,
  output logic vco_force_mid
);
  import scp_pkg::*;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic dis_w = act.ctl[CTL_DISABLE];
  wire logic [1:0] mode_w = act.ctl[CTL_MODE_HI:CTL_MODE_LO];
  wire scp_pump_mode_type mode_eff_w = dis_w ? PUMP_TRISTATE : scp_pump_mode_type'(mode_w);

  // registered outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pump_current_code <= RST_PUMP_CURRENT;
      pump_current_spi_en <= 1'b0;
      pump_mode <= PUMP_NORMAL;
      abl_spi_en <= 1'b0;
      abl_period <= ABL_MIN;
      fb_edge_falling <= 1'b0;
      ref_edge_falling <= 1'b0;
      vco_force_mid <= 1'b0;
    end else begin
      pump_current_code <= act.cur;
      pump_current_spi_en <= act.ctl[CTL_CUR_EN];
      pump_mode <= mode_eff_w;
      abl_spi_en <= act.ctl[CTL_ABL_EN];
      abl_period <= scp_abl_type'(act.abl);
      fb_edge_falling <= act.ctl[CTL_FB_EDGE];
      ref_edge_falling <= act.ctl[CTL_REF_EDGE];
      vco_force_mid <= act.ctl[CTL_VCO_MID];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_disable_tristate: assert property (@(posedge clk) disable iff (reset)
    $past(act.ctl[CTL_DISABLE]) |-> pump_mode == PUMP_TRISTATE)
    else $error("disabled pump is not tristate");
  a_mode_follows: assert property (@(posedge clk) disable iff (reset)
    !$past(act.ctl[CTL_DISABLE]) |-> pump_mode == $past(act.ctl[CTL_MODE_HI:CTL_MODE_LO]))
    else $error("pump mode does not follow field");
  a_current_override: assert property (@(posedge clk) disable iff (reset)
    pump_current_spi_en == $past(act.ctl[CTL_CUR_EN]) && pump_current_code == $past(act.cur))
    else $error("pump current select wrong");
endmodule

// ### hw/scp_regs.sv
// serial port, buffered update and pump control register bank
//
// Functional notes
// - The top bit of the serial configuration byte always reads zero, fixing the port to a shared data line.
// - Bit 6 of the configuration byte selects MSB-first (zero, reset) or LSB-first shifting of bits and bytes.
// - Writing one to bit 5 of the configuration byte restores every register to default and the bit self-clears.
// - Bit 4 of the configuration byte always reads one, as only the sixteen-bit instruction form exists.
// - Bits 3 to 0 of the configuration byte read back as a mirror of bits 7 to 4.
// - Buffered registers read their active value when readback select is zero and the buffer when it is one.
// - Writing one to the update bit copies all buffers into the active registers and the bit self-clears.
// - The eight-bit pump current field sets the current magnitude and resets to 0x80.
// - The pump current field only applies when control bit 7 is one, otherwise pins choose the current.
// - Control bit 6 picks automatic (zero) or programmed (one) antibacklash period.
// - The two-bit pump mode gives tristate, pump up, pump down or normal, resetting to normal.
// - The disable bit forces the pump to behave as tristate.
// - Control bit 2 picks rising (zero) or falling (one) feedback edges for the detector.
// - Control bit 1 picks rising (zero) or falling (one) reference edges for the detector.
// - Control bit 0 forces the oscillator control voltage to midscale.
// - The antibacklash field codes minimum, low, high, maximum, resets to minimum, and needs its enable.
`timescale 1ns/1ps
module scp_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdio_in,
  output logic spi_sdio_out,
  output logic spi_sdio_oe_n,
  output logic [7:0] pump_current_code,
  output logic pump_current_spi_en,
  output scp_pkg::scp_pump_mode_type pump_mode,
  output logic abl_spi_en,
  output scp_pkg::scp_abl_type abl_period,
  output logic fb_edge_falling,
  output logic ref_edge_falling,
  output logic vco_force_mid
);
  import scp_pkg::*;

  // ---------------------------------------------------------------
  // serial clock edges
  // ---------------------------------------------------------------
  logic sel;
  logic rise;
  logic fall;

  scp_edge u_edge (
    .clk(clk),
    .reset(reset),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .sel(sel),
    .rise(rise),
    .fall(fall)
  );

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic lsb_first_r;
  logic soft_pend_r;
  logic rb_sel_r;
  logic upd_pend_r;
  logic [7:0] buf_cur_r;
  logic [7:0] buf_ctl_r;
  logic [1:0] buf_abl_r;
  logic [7:0] act_cur_r;
  logic [7:0] act_ctl_r;
  logic [1:0] act_abl_r;

  // ---------------------------------------------------------------
  // serial shifter state
  // ---------------------------------------------------------------
  scp_state_type state_r;
  scp_state_type state_nxt;
  logic [3:0] icnt_r;
  logic [2:0] dcnt_r;
  logic [INSTR_BITS-1:0] instr_r;
  logic [DATA_BITS-1:0] data_r;
  logic rw_r;
  logic [ADDR_W-1:0] addr_r;
  logic wr_go_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic sdio_out_r;
  logic oe_n_r;

  // bit positions follow the selected shift order
  wire logic [3:0] ibit_w = lsb_first_r ? icnt_r : INSTR_LAST - icnt_r;
  wire logic [2:0] dbit_w = lsb_first_r ? dcnt_r : DATA_LAST - dcnt_r;
  wire logic [ADDR_W-1:0] addr_next_w = lsb_first_r ? addr_r + ADDR_STEP : addr_r - ADDR_STEP;

  // instruction and data words with the bit arriving now merged in
  logic [INSTR_BITS-1:0] instr_w;
  logic [DATA_BITS-1:0] data_w;
  always_comb begin
    instr_w = instr_r;
    instr_w[ibit_w] = spi_sdio_in;
    data_w = data_r;
    data_w[dbit_w] = spi_sdio_in;
  end

  wire logic instr_done_w = rise && state_r == ST_INSTR && icnt_r == INSTR_LAST;
  wire logic byte_done_w = rise && state_r == ST_DATA && dcnt_r == DATA_LAST;

  // ---------------------------------------------------------------
  // shifter state machine
  // ---------------------------------------------------------------
  always_comb begin
    case (state_r)
      ST_IDLE: state_nxt = sel ? ST_INSTR : ST_IDLE;
      ST_INSTR: state_nxt = !sel ? ST_IDLE : (instr_done_w ? ST_DATA : ST_INSTR);
      ST_DATA: state_nxt = !sel ? ST_IDLE : ST_DATA;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // bit counters restart with every select
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      icnt_r <= 4'h0;
      dcnt_r <= 3'h0;
    end else if (!sel || state_r == ST_IDLE) begin
      icnt_r <= 4'h0;
      dcnt_r <= 3'h0;
    end else if (rise && state_r == ST_INSTR) begin
      icnt_r <= icnt_r + 4'h1;
    end else if (rise && state_r == ST_DATA) begin
      dcnt_r <= dcnt_r + 3'h1; // wraps for streamed bytes
    end
  end

  // capture instruction and data bits
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      instr_r <= '0;
      data_r <= '0;
    end else if (rise && state_r == ST_INSTR) begin
      instr_r <= instr_w;
    end else if (rise && state_r == ST_DATA) begin
      data_r <= data_w;
    end
  end

  // direction and address, stepping after each streamed byte
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rw_r <= 1'b0;
      addr_r <= '0;
    end else if (instr_done_w) begin
      rw_r <= instr_w[RW_BIT];
      addr_r <= instr_w[ADDR_W-1:0];
    end else if (byte_done_w) begin
      addr_r <= addr_next_w;
    end
  end

  // write strobe one cycle after the last data bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_go_r <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= 8'h00;
    end else begin
      wr_go_r <= byte_done_w && !rw_r;
      if (byte_done_w) begin
        wr_addr_r <= addr_r;
        wr_data_r <= data_w;
      end
    end
  end

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  wire logic wr_cfg_w = wr_go_r && wr_addr_r == ADDR_SERIAL_CFG;
  wire logic wr_rb_w = wr_go_r && wr_addr_r == ADDR_READBACK_SEL;
  wire logic wr_upd_w = wr_go_r && wr_addr_r == ADDR_BUF_TRANSFER;
  wire logic wr_cur_w = wr_go_r && wr_addr_r == ADDR_PUMP_CURRENT;
  wire logic wr_ctl_w = wr_go_r && wr_addr_r == ADDR_PUMP_CTRL;
  wire logic wr_abl_w = wr_go_r && wr_addr_r == ADDR_ANTIBACKLASH;
  wire logic soft_set_w = wr_cfg_w && wr_data_r[CFG_SOFT_RESET];
  wire logic upd_set_w = wr_upd_w && wr_data_r[UPDATE_BIT];

  // self-clearing pulses; a new set wins over the clear, but a pending soft reset blocks an update set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      soft_pend_r <= 1'b0;
      upd_pend_r <= 1'b0;
    end else begin
      soft_pend_r <= soft_set_w;
      upd_pend_r <= upd_set_w && !soft_pend_r;
    end
  end

  // configuration and readback select
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lsb_first_r <= 1'b0;
      rb_sel_r <= 1'b0;
    end else if (soft_pend_r) begin
      lsb_first_r <= 1'b0;
      rb_sel_r <= 1'b0;
    end else begin
      if (wr_cfg_w) begin
        lsb_first_r <= wr_data_r[CFG_LSB_FIRST];
      end
      if (wr_rb_w) begin
        rb_sel_r <= wr_data_r[READBACK_BIT];
      end
    end
  end

  // buffer registers take host writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      buf_cur_r <= RST_PUMP_CURRENT;
      buf_ctl_r <= RST_PUMP_CTRL;
      buf_abl_r <= RST_ANTIBACKLASH;
    end else if (soft_pend_r) begin
      buf_cur_r <= RST_PUMP_CURRENT;
      buf_ctl_r <= RST_PUMP_CTRL;
      buf_abl_r <= RST_ANTIBACKLASH;
    end else begin
      if (wr_cur_w) begin
        buf_cur_r <= wr_data_r;
      end
      if (wr_ctl_w) begin
        buf_ctl_r <= wr_data_r;
      end
      if (wr_abl_w) begin
        buf_abl_r <= wr_data_r[ABL_HI:ABL_LO];
      end
    end
  end

  // active registers load from the buffers on update
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      act_cur_r <= RST_PUMP_CURRENT;
      act_ctl_r <= RST_PUMP_CTRL;
      act_abl_r <= RST_ANTIBACKLASH;
    end else if (soft_pend_r) begin
      act_cur_r <= RST_PUMP_CURRENT;
      act_ctl_r <= RST_PUMP_CTRL;
      act_abl_r <= RST_ANTIBACKLASH;
    end else if (upd_pend_r) begin
      act_cur_r <= buf_cur_r;
      act_ctl_r <= buf_ctl_r;
      act_abl_r <= buf_abl_r;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire logic [3:0] cfg_hi_w = {1'b0, lsb_first_r, soft_pend_r, 1'b1};
  wire logic [7:0] cfg_rd_w = {cfg_hi_w, cfg_hi_w};
  wire logic [7:0] cur_rd_w = rb_sel_r ? buf_cur_r : act_cur_r;
  wire logic [7:0] ctl_rd_w = rb_sel_r ? buf_ctl_r : act_ctl_r;
  wire logic [1:0] abl_rd_w = rb_sel_r ? buf_abl_r : act_abl_r;
  logic [7:0] rd_val_w;
  always_comb begin
    case (addr_r)
      ADDR_SERIAL_CFG: rd_val_w = cfg_rd_w;
      ADDR_READBACK_SEL: rd_val_w = {7'h00, rb_sel_r};
      ADDR_BUF_TRANSFER: rd_val_w = {7'h00, upd_pend_r};
      ADDR_PUMP_CURRENT: rd_val_w = cur_rd_w;
      ADDR_PUMP_CTRL: rd_val_w = ctl_rd_w;
      ADDR_ANTIBACKLASH: rd_val_w = {abl_rd_w, 6'h00};
      default: rd_val_w = 8'h00;
    endcase
  end

  // read data leaves on falling edges of the serial clock
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sdio_out_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else if (!sel) begin
      oe_n_r <= 1'b1;
    end else if (fall && state_r == ST_DATA && rw_r) begin
      sdio_out_r <= rd_val_w[dbit_w];
      oe_n_r <= 1'b0;
    end
  end

  assign spi_sdio_out = sdio_out_r;
  assign spi_sdio_oe_n = oe_n_r;

  // ---------------------------------------------------------------
  // pump decode
  // ---------------------------------------------------------------
  scp_pump_if act_if ();
  assign act_if.cur = act_cur_r;
  assign act_if.ctl = act_ctl_r;
  assign act_if.abl = act_abl_r;

  scp_pump_decode u_dec (
    .clk(clk),
    .reset(reset),
    .act(act_if),
    .pump_current_code(pump_current_code),
    .pump_current_spi_en(pump_current_spi_en),
    .pump_mode(pump_mode),
    .abl_spi_en(abl_spi_en),
    .abl_period(abl_period),
    .fb_edge_falling(fb_edge_falling),
    .ref_edge_falling(ref_edge_falling),
    .vco_force_mid(vco_force_mid)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_cfg_top_zero: assert property (@(posedge clk) disable iff (reset)
    cfg_rd_w[7] == 1'b0)
    else $error("config top bit not zero");
  a_cfg_bit_four: assert property (@(posedge clk) disable iff (reset)
    cfg_rd_w[4] == 1'b1 && cfg_rd_w[0] == 1'b1)
    else $error("config bit four not one");
  a_cfg_mirror: assert property (@(posedge clk) disable iff (reset)
    cfg_rd_w[3:0] == cfg_rd_w[7:4])
    else $error("config nibble not mirrored");
  a_soft_reset_done: assert property (@(posedge clk) disable iff (reset)
    soft_set_w |=> soft_pend_r ##1 (!soft_pend_r && !lsb_first_r && act_cur_r == RST_PUMP_CURRENT
      && buf_ctl_r == RST_PUMP_CTRL))
    else $error("soft reset did not restore defaults");
  a_update_copies: assert property (@(posedge clk) disable iff (reset)
    upd_pend_r && !soft_pend_r |=> act_cur_r == $past(buf_cur_r) && act_ctl_r == $past(buf_ctl_r))
    else $error("update did not copy buffers");
  a_update_selfclear: assert property (@(posedge clk) disable iff (reset)
    upd_pend_r && !upd_set_w |=> !upd_pend_r)
    else $error("update bit did not clear");
  a_active_holds: assert property (@(posedge clk) disable iff (reset)
    !upd_pend_r && !soft_pend_r |=> $stable(act_ctl_r) && $stable(act_abl_r))
    else $error("active register changed without update");
  a_readback_select: assert property (@(posedge clk) disable iff (reset)
    fall && state_r == ST_DATA && rw_r && addr_r == ADDR_PUMP_CTRL
      |=> spi_sdio_out == (rb_sel_r ? buf_ctl_r[$past(dbit_w)] : act_ctl_r[$past(dbit_w)]))
    else $error("readback selects wrong copy");
  a_order_msb: assert property (@(posedge clk) disable iff (reset)
    rise && state_r == ST_INSTR && icnt_r == 4'h0 && !lsb_first_r
      |=> instr_r[INSTR_BITS-1] == $past(spi_sdio_in))
    else $error("msb first order wrong");
endmodule

// ### verif/scp_spi_host.sv
// serial port host model that frames register reads and writes
`timescale 1ns/1ps
module scp_spi_host (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic sdo,
  output logic drv,
  input wire logic sdi
);
  localparam int HALF = 6;
  logic lsb_r;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdo = 1'b0;
    drv = 1'b0;
    lsb_r = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  // one bit: data set while clock low, sampled by both ends at the rise
  task automatic shift(input logic b, input logic out, output logic got);
    drv = out;
    sdo = out ? b : ~sdo; // released line shows the inverse of the last bit
    tick(HALF);
    sclk = 1'b1;
    got = sdi;
    tick(HALF);
    sclk = 1'b0;
  endtask
  // ---------------------------------------------------------------
  // one framed transfer of a single byte
  // ---------------------------------------------------------------
  task automatic frame(input logic rd, input logic [12:0] addr, input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] ins;
    logic g;
    ins = {rd, 2'b00, addr};
    rdat = 8'h00;
    cs_n = 1'b0;
    for (int k = 0; k < 16; k++) shift(lsb_r ? ins[k] : ins[15-k], 1'b1, g);
    for (int k = 0; k < 8; k++) begin
      shift(lsb_r ? wd[k] : wd[7-k], !rd, g);
      rdat[lsb_r ? k : 7-k] = g;
    end
    tick(HALF);
    drv = 1'b0;
    cs_n = 1'b1;
    sdo = ~sdo;
    tick(HALF);
    if (!rd && addr == 13'h0000) lsb_r = wd[5] ? 1'b0 : wd[6];
  endtask
  // two streamed read bytes in one frame; first byte lands in the upper half
  task automatic frame2(input logic [12:0] addr, output logic [15:0] rdat);
    logic [15:0] ins;
    logic g;
    ins = {1'b1, 2'b00, addr};
    rdat = 16'h0000;
    cs_n = 1'b0;
    for (int k = 0; k < 16; k++) shift(lsb_r ? ins[k] : ins[15-k], 1'b1, g);
    for (int k = 0; k < 16; k++) begin
      shift(1'b0, 1'b0, g);
      rdat[(k < 8 ? 8 : 0) + (lsb_r ? k % 8 : 7 - k % 8)] = g;
    end
    tick(HALF);
    drv = 1'b0;
    cs_n = 1'b1;
    sdo = ~sdo;
    tick(HALF);
  endtask
endmodule

// ### verif/testbench.sv
// self-checking bench for the serial config and pump control register bank
`timescale 1ns/1ps
module testbench;
  import scp_pkg::*;
  logic clk, reset, sclk, cs_n, host_sdo, host_drv, sdio, sdio_out, oe_n;
  logic cur_en, abl_en, fb_fall, ref_fall, vco_mid;
  logic [7:0] cur_code, rdat;
  logic [7:0] bf[3], ac[3];
  logic [17:0] outs;
  logic [31:0] r;
  logic m_lsb, m_sel;
  scp_pump_mode_type mode;
  scp_abl_type abl;
  int errors, samples_checked, i;
  int seed = 32'hd836;
  initial clk = 1'b0;
  always #25 clk = ~clk;
  // data line level: device drives while its enable is low
  assign sdio = !oe_n ? sdio_out : host_sdo;
  assign outs = {oe_n, cur_code, cur_en, abl_en, mode, abl, fb_fall, ref_fall, vco_mid};
  scp_regs i_dut (
    .clk(clk), .reset(reset), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdio_in(sdio),
    .spi_sdio_out(sdio_out), .spi_sdio_oe_n(oe_n), .pump_current_code(cur_code),
    .pump_current_spi_en(cur_en), .pump_mode(mode), .abl_spi_en(abl_en), .abl_period(abl),
    .fb_edge_falling(fb_fall), .ref_edge_falling(ref_fall), .vco_force_mid(vco_mid)
  );
  scp_spi_host i_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdo(host_sdo), .drv(host_drv), .sdi(sdio));
  // ---------------------------------------------------------------
  // reference model and checks
  // ---------------------------------------------------------------
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic mreset();
    m_lsb = 1'b0;
    m_sel = 1'b0;
    bf = '{8'h80, 8'h30, 8'h00};
    ac = bf;
  endtask
  function automatic logic [17:0] exp_out();
    return {1'b1, ac[0], ac[1][7], ac[1][6], ac[1][3] ? 2'b00 : ac[1][5:4], ac[2][7:6], ac[1][2:0]};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [12:0] a);
    case (a)
      13'h0000: return m_lsb ? 8'h55 : 8'h11;
      13'h0004: return {7'h00, m_sel};
      13'h000A: return m_sel ? bf[0] : ac[0];
      13'h000B: return m_sel ? bf[1] : ac[1];
      13'h000D: return m_sel ? bf[2] : ac[2];
      default: return 8'h00;
    endcase
  endfunction
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    i_host.frame(1'b0, a, d, rdat);
    case (a)
      13'h0000: if (d[5]) mreset(); else m_lsb = d[6];
      13'h0004: m_sel = d[0];
      13'h0005: if (d[0]) ac = bf;
      13'h000A: bf[0] = d;
      13'h000B: bf[1] = d;
      13'h000D: bf[2] = d & 8'hC0;
      default: ;
    endcase
    i_host.tick(4);
    chk(outs, exp_out());
  endtask
  task automatic rd(input logic [12:0] a);
    i_host.frame(1'b1, a, 8'h00, rdat);
    chk({10'h000, rdat}, {10'h000, exp_rd(a)});
  endtask
  // streamed read: the second byte comes from the stepped address b
  task automatic rd2(input logic [12:0] a, input logic [12:0] b);
    logic [15:0] d;
    i_host.frame2(a, d);
    chk({2'b00, d}, {2'b00, exp_rd(a), exp_rd(b)});
  endtask
  task automatic end_sim();
    $display("TB: errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // both ends must never drive the data line together
  always @(posedge clk) begin
    if (host_drv && !oe_n && !reset) begin
      errors++;
      $display("ERROR %0t: data line driven from both ends", $time);
    end
  end
  // watchdog against a hung handshake
  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    $display("ERROR %0t: watchdog expired", $time);
    end_sim();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset = 1'b1;
    errors = 0;
    samples_checked = 0;
    mreset();
    repeat (20) @(posedge clk);
    #1 reset = 1'b0;
    i_host.tick(2);
    chk(outs, exp_out());
    rd(13'h0000);
    rd(13'h000A);
    rd(13'h000B);
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      wr(13'h000A, r[7:0]);
      wr(13'h000B, {r[15:14], i[1:0], i[2], r[10:8]});
      wr(13'h000D, r[23:16]);
      wr(13'h0004, {7'h00, r[24]});
      rd(13'h000A);
      rd(13'h000B);
      rd(13'h000D);
      wr(13'h0005, 8'h01);
      rd(13'h0005);
    end
    rd2(13'h000B, 13'h000A);
    wr(13'h0000, 8'hCF);
    rd(13'h0000);
    wr(13'h000A, 8'h5A);
    wr(13'h0005, 8'h01);
    rd(13'h000A);
    rd2(13'h000A, 13'h000B);
    wr(13'h000C, 8'hAA);
    rd(13'h000C);
    rd(13'h1FFF);
    wr(13'h0000, 8'h20);
    rd(13'h0000);
    rd(13'h000A);
    rd(13'h000B);
    end_sim();
  end
endmodule
